//--- verilog/pevc_pkg.sv
// Constants, field layout and carrier types of the power event pin control.
//
// Notes on behaviour
// - Two event pins: unrouted, driven by routed conditions, or set by software.
// - Any active routed condition drives its pin active.
// - Software pin level applies only while nothing is routed to that pin.
// - Six limits: sag, surge, over-current and over-power per channel.
// - Over-current and over-power are checked once per computation cycle.
// - Sag and surge resolve within a line cycle and can be held by bits 7 and 6.
// - Trailing mean square over half a line period, scaled by the window.
// - Each data-ready compares the mean square against sag and surge limits.
// - An active routed sag or surge drives its pin high.
// - Top eight bits report calibration failures; success clears them.
// - Calibration bits: 31 reactive2 down to 24 line frequency.
// - Bits 23..20 route over-power, over-current, surge, sag to pin 2.
// - Bits 19..16 route over-power, over-current, surge, sag to pin 1.
// - Bits 15 and 14 give software levels of pins 2 and 1.
// - Writing one to bits 11..8 clears over-current, over-power, surge, sag.
// - Bits 7 and 6 latch surge and sag until cleared.
// - Bits 13 and 12 are unimplemented and read zero.
// - Bits 5 and 4 latch over-power and over-current until cleared.
// - Bits 3..0 force simulated surge, sag, over-power, over-current.
package pevc_pkg;

    // Register byte addresses.
    localparam logic [7:0] OFS_EVENT = 8'h00;
    localparam logic [7:0] OFS_SAG_LIMIT = 8'h04;
    localparam logic [7:0] OFS_SURGE_LIMIT = 8'h08;
    localparam logic [7:0] OFS_OC1_LIMIT = 8'h0c;
    localparam logic [7:0] OFS_OP1_LIMIT = 8'h10;
    localparam logic [7:0] OFS_OC2_LIMIT = 8'h14;
    localparam logic [7:0] OFS_OP2_LIMIT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MEAN_SQ = 8'h20;

    // Event register field positions.
    localparam int POS_CAL = 24;
    localparam int POS_ROUTE2 = 20;
    localparam int POS_ROUTE1 = 16;
    localparam int POS_SOFT2 = 15;
    localparam int POS_SOFT1 = 14;
    localparam int POS_CLEAR = 8;
    localparam int POS_HOLD = 4;
    localparam int POS_SIM = 0;

    // Condition indices inside the four-bit hold and simulate groups and the condition flags.
    localparam int IX_OVERCUR = 0;
    localparam int IX_OVERPOW = 1;
    localparam int IX_SAG = 2;
    localparam int IX_SURGE = 3;

    // Values after reset.
    localparam logic [31:0] RST_EVENT = 32'h0000_0000;
    localparam logic [31:0] RST_LIMIT = 32'h0000_0000;

    // Trailing window length in samples: sample rate over twice line rate.
    localparam int WIN_LOG2 = 5;
    localparam int WIN_LEN = 1 << WIN_LOG2;

    typedef struct packed {
        logic valid;
        logic signed [15:0] value;
    } pevc_sample_t;

    typedef struct packed {
        logic valid;
        logic [31:0] current1;
        logic [31:0] current2;
        logic [31:0] power1;
        logic [31:0] power2;
    } pevc_results_t;

    typedef struct packed {
        logic done;
        logic [7:0] select;
        logic [7:0] pass;
    } pevc_cal_t;

endpackage : pevc_pkg

//--- verilog/pevc_top.sv
// Event detection, routing and pin drive of the power event pin control.
`timescale 1ns/1ps

module pevc_top (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Measurement engine
    input wire pevc_pkg::pevc_sample_t vsample,
    input wire logic data_ready,
    input wire pevc_pkg::pevc_results_t results,
    // Calibration outcome
    input wire pevc_pkg::pevc_cal_t cal,
    // Event pins
    output logic event_pin1,
    output logic event_pin2
);

    localparam int SUM_W = 32 + pevc_pkg::WIN_LOG2;

    // Picks the four-bit group of a condition set at a given position.
    function automatic logic [3:0] field4(input logic [31:0] w, input int pos);
        field4 = w[pos +: 4];
    endfunction : field4

    // Route bit order in a pin group is over-power, over-current, surge, sag.
    function automatic logic [3:0] route_to_cond(input logic [3:0] r);
        logic [3:0] c;
        c = 4'h0;
        c[pevc_pkg::IX_OVERPOW] = r[3];
        c[pevc_pkg::IX_OVERCUR] = r[2];
        c[pevc_pkg::IX_SURGE] = r[1];
        c[pevc_pkg::IX_SAG] = r[0];
        route_to_cond = c;
    endfunction : route_to_cond

    // Clear bit order is over-current, over-power, surge, sag.
    function automatic logic [3:0] clr_to_cond(input logic [3:0] r);
        logic [3:0] c;
        c = 4'h0;
        c[pevc_pkg::IX_OVERCUR] = r[3];
        c[pevc_pkg::IX_OVERPOW] = r[2];
        c[pevc_pkg::IX_SURGE] = r[1];
        c[pevc_pkg::IX_SAG] = r[0];
        clr_to_cond = c;
    endfunction : clr_to_cond

    // Hold and simulate order is surge, sag, over-power, over-current.
    function automatic logic [3:0] ctl_to_cond(input logic [3:0] r);
        logic [3:0] c;
        c = 4'h0;
        c[pevc_pkg::IX_SURGE] = r[3];
        c[pevc_pkg::IX_SAG] = r[2];
        c[pevc_pkg::IX_OVERPOW] = r[1];
        c[pevc_pkg::IX_OVERCUR] = r[0];
        ctl_to_cond = c;
    endfunction : ctl_to_cond

    // Stored state.
    logic [7:0] cal_fail_reg;
    logic [7:0] route_reg;
    logic [1:0] soft_level_reg;
    logic [3:0] hold_reg;
    logic [3:0] simulate_reg;
    logic [31:0] limit_reg [6];
    logic [3:0] cond_reg;
    logic [31:0] sq_mem [pevc_pkg::WIN_LEN];
    logic [pevc_pkg::WIN_LOG2-1:0] win_ptr_reg;
    logic [SUM_W-1:0] win_sum_reg;
    logic [31:0] rdata_reg;
    logic event_pin1_reg;
    logic event_pin2_reg;

    // Address decode.
    wire logic wr_event = wr_en && (addr == pevc_pkg::OFS_EVENT);
    wire logic [2:0] limit_idx = 3'((addr - pevc_pkg::OFS_SAG_LIMIT) >> 2);
    wire logic addr_is_limit = (addr >= pevc_pkg::OFS_SAG_LIMIT) &&
        (addr <= pevc_pkg::OFS_OP2_LIMIT) && (addr[1:0] == 2'b00);

    // Limits: 0 sag, 1 surge, 2 over-current ch1, 3 over-power ch1,
    // 4 over-current ch2, 5 over-power ch2.
    wire logic [31:0] sag_limit = limit_reg[0];
    wire logic [31:0] surge_limit = limit_reg[1];

    // Trailing mean square of the voltage samples.
    wire logic [31:0] new_sq = 32'(vsample.value * vsample.value);
    wire logic [31:0] old_sq = sq_mem[win_ptr_reg];
    wire logic [SUM_W-1:0] win_sum_next =
        win_sum_reg + SUM_W'(new_sq) - SUM_W'(old_sq);
    // A power-of-two window turns the reciprocal scale into a shift.
    wire logic [31:0] mean_sq = 32'(win_sum_reg >> pevc_pkg::WIN_LOG2);

    // Comparisons.
    wire logic sag_hit = mean_sq < sag_limit;
    wire logic surge_hit = mean_sq > surge_limit;
    wire logic oc_hit = (results.current1 > limit_reg[2]) ||
        (results.current2 > limit_reg[4]);
    wire logic op_hit = (results.power1 > limit_reg[3]) ||
        (results.power2 > limit_reg[5]);

    wire logic [3:0] hit;
    wire logic [3:0] evaluate;
    assign hit[pevc_pkg::IX_OVERCUR] = oc_hit;
    assign hit[pevc_pkg::IX_OVERPOW] = op_hit;
    assign hit[pevc_pkg::IX_SAG] = sag_hit;
    assign hit[pevc_pkg::IX_SURGE] = surge_hit;
    assign evaluate[pevc_pkg::IX_OVERCUR] = results.valid;
    assign evaluate[pevc_pkg::IX_OVERPOW] = results.valid;
    assign evaluate[pevc_pkg::IX_SAG] = data_ready;
    assign evaluate[pevc_pkg::IX_SURGE] = data_ready;

    wire logic [3:0] clear_cmd = wr_event ?
        clr_to_cond(field4(wdata, pevc_pkg::POS_CLEAR + 0)) : 4'h0;
    wire logic [3:0] hold_cond = ctl_to_cond(hold_reg);
    wire logic [3:0] sim_cond = ctl_to_cond(simulate_reg);

    // Condition flags, one per event kind.
    logic [3:0] cond_next;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cond
            wire logic set_now = evaluate[g] && hit[g];
            // A detection in the clearing cycle wins over the clear.
            assign cond_next[g] =
                set_now ? 1'b1 :
                (hold_cond[g] && !clear_cmd[g]) ? cond_reg[g] :
                clear_cmd[g] ? 1'b0 :
                evaluate[g] ? 1'b0 :
                cond_reg[g];
        end
    endgenerate

    wire logic [3:0] cond_active = cond_reg | sim_cond;

    // Pin drive.
    wire logic [3:0] routed1 =
        route_to_cond(route_reg[pevc_pkg::POS_ROUTE1-16 +: 4]);
    wire logic [3:0] routed2 =
        route_to_cond(route_reg[pevc_pkg::POS_ROUTE2-16 +: 4]);
    wire logic pin1_next = (|routed1) ?
        |(routed1 & cond_active) : soft_level_reg[0];
    wire logic pin2_next = (|routed2) ?
        |(routed2 & cond_active) : soft_level_reg[1];

    // Calibration result bits; a hardware outcome overrides a write.
    logic [7:0] cal_next;
    generate
        for (g = 0; g < 8; g++) begin : g_cal
            wire logic sw_val = wr_event ?
                wdata[pevc_pkg::POS_CAL + g] : cal_fail_reg[g];
            assign cal_next[g] = (cal.done && cal.select[g]) ?
                !cal.pass[g] : sw_val;
        end
    endgenerate

    // Read view; clear bits are actions and read back as zero.
    wire logic [31:0] event_view = {
        cal_fail_reg,
        route_reg,
        soft_level_reg,
        2'b00,
        4'h0,
        hold_reg,
        simulate_reg
    };
    wire logic [31:0] status_view = {26'h0, event_pin2_reg, event_pin1_reg,
        cond_active};
    wire logic [31:0] read_mux =
        (addr == pevc_pkg::OFS_EVENT) ? event_view :
        addr_is_limit ? limit_reg[limit_idx] :
        (addr == pevc_pkg::OFS_STATUS) ? status_view :
        (addr == pevc_pkg::OFS_MEAN_SQ) ? mean_sq :
        32'h0000_0000;

    // Control register storage.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cal_fail_reg <= pevc_pkg::RST_EVENT[31:24];
            route_reg <= pevc_pkg::RST_EVENT[23:16];
            soft_level_reg <= pevc_pkg::RST_EVENT[15:14];
            hold_reg <= pevc_pkg::RST_EVENT[7:4];
            simulate_reg <= pevc_pkg::RST_EVENT[3:0];
        end else if (ce) begin
            cal_fail_reg <= cal_next;
            if (wr_event) begin
                route_reg <= wdata[pevc_pkg::POS_ROUTE1 +: 8];
                soft_level_reg <= wdata[pevc_pkg::POS_SOFT1 +: 2];
                hold_reg <= wdata[pevc_pkg::POS_HOLD +: 4];
                simulate_reg <= wdata[pevc_pkg::POS_SIM +: 4];
            end
        end
    end

    // Limit registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 6; i++) begin
                limit_reg[i] <= pevc_pkg::RST_LIMIT;
            end
        end else if (ce && wr_en && addr_is_limit) begin
            limit_reg[limit_idx] <= wdata;
        end
    end

    // Condition flags.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cond_reg <= 4'h0;
        end else if (ce) begin
            cond_reg <= cond_next;
        end
    end

    // Squared sample history for the running sum.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < pevc_pkg::WIN_LEN; i++) begin
                sq_mem[i] <= 32'h0000_0000;
            end
            win_ptr_reg <= '0;
            win_sum_reg <= '0;
        end else if (ce && vsample.valid) begin
            sq_mem[win_ptr_reg] <= new_sq;
            win_ptr_reg <= win_ptr_reg + 1'b1;
            win_sum_reg <= win_sum_next;
        end
    end

    // Pins and read data.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_pin1_reg <= 1'b0;
            event_pin2_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            event_pin1_reg <= pin1_next;
            event_pin2_reg <= pin2_next;
            rdata_reg <= rd_en ? read_mux : 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;
    assign event_pin1 = event_pin1_reg;
    assign event_pin2 = event_pin2_reg;

endmodule : pevc_top

//--- testbench/pevc_top_chk.sv
// Port-level assertions of the power event pin control.
`timescale 1ns/1ps

module pevc_top_chk (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    // Measurement and pins
    input wire logic data_ready,
    input wire pevc_pkg::pevc_results_t results,
    input wire logic event_pin1,
    input wire logic event_pin2
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ev_wr;
        ce && wr_en && addr == pevc_pkg::OFS_EVENT;
    endsequence

    sequence s_ev_rd;
        ce && rd_en && addr == pevc_pkg::OFS_EVENT;
    endsequence

    // Pins may only move two cycles after something that can move them.
    sequence s_quiet;
        (ce && !wr_en && !data_ready && !results.valid)[*3];
    endsequence

    a_unimpl_zero: assert property (
        s_ev_rd |=> rdata[13:12] == 2'h0) else $error("bits 13:12 not 0");
    a_clear_reads0: assert property (
        s_ev_rd |=> rdata[11:8] == 4'h0) else $error("clear bits not 0");
    a_soft_pin1: assert property (
        (s_ev_wr and wdata[19:16] == 4'h0) ##1 ce
        |=> event_pin1 == $past(wdata[14], 2)) else $error("pin1 soft");
    a_soft_pin2: assert property (
        (s_ev_wr and wdata[23:20] == 4'h0) ##1 ce
        |=> event_pin2 == $past(wdata[15], 2)) else $error("pin2 soft");
    a_sim_pin1: assert property (
        (s_ev_wr and wdata[16] && wdata[2]) ##1 ce
        |=> event_pin1) else $error("simulated sag not on pin1");
    a_any_pin2: assert property (
        (s_ev_wr and |(wdata[23:20] & {wdata[1:0], wdata[3:2]})) ##1 ce
        |=> event_pin2) else $error("routed condition not on pin2");
    a_pin1_cause: assert property (
        $rose(event_pin1) && $past(ce) && $past(ce, 2)
        |-> $past(wr_en || data_ready || results.valid, 2))
        else $error("pin1 rose without cause");
    a_pins_quiet: assert property (
        s_quiet |-> $stable(event_pin1) && $stable(event_pin2))
        else $error("pins moved without cause");
endmodule : pevc_top_chk

bind pevc_top pevc_top_chk chk_u (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .data_ready(data_ready),
    .results(results),
    .event_pin1(event_pin1),
    .event_pin2(event_pin2)
);

//--- testbench/pevc_irq_sink.sv
// Interrupt input model that counts rising edges on both event pins.
`timescale 1ns/1ps

module pevc_irq_sink (
    // Clock and reset
    clk,
    reset,
    // Event pins and edge counts
    pin1,
    pin2,
    count1,
    count2
);
    input wire logic clk;
    input wire logic reset;
    input wire logic pin1;
    input wire logic pin2;
    output logic [7:0] count1;
    output logic [7:0] count2;
    logic last1_reg;
    logic last2_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {last1_reg, last2_reg, count1, count2} <= '0;
        end else begin
            last1_reg <= pin1;
            last2_reg <= pin2;
            count1 <= count1 + 8'(pin1 && !last1_reg);
            count2 <= count2 + 8'(pin2 && !last2_reg);
        end
    end
endmodule : pevc_irq_sink

//--- testbench/pevc_top_test.sv
// Self-checking bench of the power event pin control.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
end

module pevc_top_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    pevc_pkg::pevc_sample_t vsample = '0;
    logic data_ready = 1'b0;
    pevc_pkg::pevc_results_t results = '0;
    pevc_pkg::pevc_cal_t cal = '0;
    logic pin1;
    logic pin2;
    logic [7:0] cnt1;
    logic [7:0] cnt2;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0001_3493;

    pevc_top dut_u (.clk(clk), .reset(reset), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .vsample(vsample), .data_ready(data_ready), .results(results),
        .cal(cal), .event_pin1(pin1), .event_pin2(pin2));
    pevc_irq_sink sink_u (.clk(clk), .reset(reset), .pin1(pin1),
        .pin2(pin2), .count1(cnt1), .count2(cnt2));

    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Equal samples make the trailing mean exactly one square.
    function automatic logic [31:0] msq(input logic [15:0] v);
        return {16'h0, v} * {16'h0, v};
    endfunction : msq

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
        @(posedge clk);
    endtask : rd

    task automatic pins(input logic e1, input logic e2);
        repeat (2) @(posedge clk);
        #1;
        `CHK("pin1", e1, pin1)
        `CHK("pin2", e2, pin2)
        @(posedge clk);
    endtask : pins

    task automatic ev(input logic e1, input logic e2);
        data_ready <= 1'b1;
        @(posedge clk);
        data_ready <= 1'b0;
        pins(e1, e2);
    endtask : ev

    task automatic res(input logic [31:0] c, input logic [31:0] p,
                       input logic e1, input logic e2);
        results <= {1'b1, c, 32'h0, 32'h0, p};
        @(posedge clk);
        results <= '0;
        pins(e1, e2);
    endtask : res

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] d;
        logic [31:0] m;
        logic [15:0] v;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(pevc_pkg::OFS_EVENT, 32'h0);
        rd(8'h24, 32'h0);
        wr(pevc_pkg::OFS_EVENT, 32'h0000_4000);
        pins(1'b1, 1'b0);
        wr(pevc_pkg::OFS_EVENT, 32'h0001_4000);
        pins(1'b0, 1'b0);
        d = rnd();
        v = d[15:0] & 16'h0fff | 16'h0001;
        m = msq(v);
        repeat (32) begin
            vsample <= {1'b1, v};
            @(posedge clk);
        end
        vsample <= '0;
        @(posedge clk);
        rd(pevc_pkg::OFS_MEAN_SQ, m);
        wr(pevc_pkg::OFS_SAG_LIMIT, m + 32'h1);
        wr(pevc_pkg::OFS_SURGE_LIMIT, m);
        wr(pevc_pkg::OFS_EVENT, 32'h0021_0000);
        ev(1'b1, 1'b0);
        rd(pevc_pkg::OFS_STATUS, 32'h0000_0014);
        wr(pevc_pkg::OFS_SAG_LIMIT, m);
        wr(pevc_pkg::OFS_SURGE_LIMIT, m - 32'h1);
        ev(1'b0, 1'b1);
        wr(pevc_pkg::OFS_EVENT, 32'h0021_00c0);
        wr(pevc_pkg::OFS_SURGE_LIMIT, m);
        ev(1'b0, 1'b1);
        wr(pevc_pkg::OFS_EVENT, 32'h0021_02c0);
        pins(1'b0, 1'b0);
        d = rnd() & 32'h00ff_ffff;
        wr(pevc_pkg::OFS_OC1_LIMIT, d);
        wr(pevc_pkg::OFS_OP2_LIMIT, d);
        wr(pevc_pkg::OFS_EVENT, 32'h0084_0010);
        res(d + 32'h1, d, 1'b1, 1'b0);
        res(d, d, 1'b1, 1'b0);
        res(d, d + 32'h1, 1'b1, 1'b1);
        wr(pevc_pkg::OFS_EVENT, 32'h0084_0810);
        res(32'h0, d + 32'h1, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(pevc_pkg::OFS_EVENT, 32'h000f_0f00 | (32'h1 << k));
            pins(1'b1, 1'b0);
        end
        wr(pevc_pkg::OFS_EVENT, 32'h000f_0f00);
        pins(1'b0, 1'b0);
        `CHK("edges1", 8'h04, cnt1)
        `CHK("edges2", 8'h02, cnt2)
        cal <= {1'b1, 8'h0f, 8'h05};
        @(posedge clk);
        cal <= {1'b1, 8'h08, 8'h08};
        @(posedge clk);
        cal <= '0;
        rd(pevc_pkg::OFS_EVENT, 32'h020f_0000);
        for (int i = 0; i < 14; i++) begin
            d = rnd();
            wr(8'(4 * (i % 7)), d);
            rd(8'(4 * (i % 7)), i % 7 == 0 ? d & 32'hffff_c0ff : d);
        end
        // A write while the clock enable is low must leave the limit alone.
        wr(pevc_pkg::OFS_SAG_LIMIT, 32'h0000_1234);
        ce <= 1'b0;
        wr(pevc_pkg::OFS_SAG_LIMIT, 32'h0000_5678);
        ce <= 1'b1;
        rd(pevc_pkg::OFS_SAG_LIMIT, 32'h0000_1234);
        end_of_test();
    end
endmodule : pevc_top_test
